/* hw/startup_burst_control.sv */
// Register access over Avalon-MM and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Request start-up once supply passes turn-on threshold after reset or restart.
// - Brown-in, no input overvoltage and feedback above burst control within check period.
// - Check overtemperature release only after the first three conditions hold.
// - Any failed condition falls back to bang-bang supply charging.
// - With all conditions valid, compute maximum high-side on-time from input voltage.
// - Issue one low-side bootstrap precharge pulse before first high-side pulse.
// - Fixed start-up zvs pulse until sense passes threshold, then shorten it.
// - Count half-bridge cycles; after search timeout without zero crossing, pulse again.
// - Too many cycles without zero crossing enters output short protection.
// - Start peak setting at first overcurrent setpoint, hold until sense threshold.
// - Then raise setting linearly below target and lower it above target.
// - Raise sense target one step per slow task period.
// - Clamp start-up current setpoint to start-up maximum.
// - Sense above valley-to-resonant threshold switches to continuous resonant mode.
// - End start-up when feedback setting falls below ramp setting.
// - Start-up longer than timeout raises start-up timeout protection.
// - Feedback below burst entry suppresses next pulse and enters sleep.
// - In burst mode use fixed minimum peak current setting.
// - Use high-voltage start-up cell once at burst entry.
// - Sleep on falling control crossing after a pulse, wake on rising.
// - Burst on-frame uses valley switching triggered at first valley.
// - Precharge pulse at on-frame start only after sleep above threshold.
module startup_burst_control (
  input  wire logic                                clk,
  input  wire logic                                rst_b,
  input  wire logic [startup_burst_pkg::ADDR_W-1:0] avs_address,
  input  wire logic                                avs_read,
  input  wire logic                                avs_write,
  input  wire logic [startup_burst_pkg::DATA_W-1:0] avs_writedata,
  output logic      [startup_burst_pkg::DATA_W-1:0] avs_readdata,
  output logic                                     avs_waitrequest,
  input  wire startup_burst_pkg::comp_s             comp_raw,
  input  wire logic [startup_burst_pkg::LVL_W-1:0]  input_level,
  input  wire logic [startup_burst_pkg::LVL_W-1:0]  fb_setpoint,
  output startup_burst_pkg::drive_s                 drive,
  output logic      [startup_burst_pkg::LVL_W-1:0]  peak_setpoint,
  output logic      [startup_burst_pkg::LVL_W-1:0]  zvs_len,
  output logic      [startup_burst_pkg::LVL_W-1:0]  hs_on_max,
  output logic                                     shunt_short_protection,
  output logic                                     output_short_protection,
  output logic                                     startup_timeout_protection
);
  import startup_burst_pkg::*;

  localparam logic [31:0] SLOW_TASK_C = 32'(SLOW_TASK_CYCLES);
  localparam logic [31:0] STARTUP_TO_C = 32'(STARTUP_TIMEOUT_CYCLES);

  comp_s       sync1_q;
  comp_s       comp_q;
  comp_s       comp_prev_q;
  seq_state_e  state_q;
  logic [31:0] ctrl_q;
  logic [15:0] timer_q;
  logic [15:0] cycles_q;
  logic [31:0] slow_q;
  logic [31:0] st_time_q;
  logic [23:0] sleep_time_q;
  logic [23:0] sleep_cap_q;
  logic [LVL_W-1:0] target_q;
  logic        pulsed_q;
  logic        ack_q;
  logic        start_req;
  logic        clr_prot;
  logic        in_startup;
  logic        slow_tick;
  logic        fb_fall;
  logic        fb_rise;
  logic        sense_level_hi;

  // Two-flop synchroniser; comparators are asynchronous to clk
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sync1_q     <= '0;
      comp_q      <= '0;
      comp_prev_q <= '0;
    end else begin
      sync1_q     <= comp_raw;
      comp_q      <= sync1_q;
      comp_prev_q <= comp_q;
    end
  end

  assign fb_fall = comp_prev_q.fb_above_burst_ctrl & ~comp_q.fb_above_burst_ctrl;
  assign fb_rise = ~comp_prev_q.fb_above_burst_ctrl & comp_q.fb_above_burst_ctrl;
  assign start_req = ctrl_q[CTRL_START_BIT] & comp_q.supply_on;
  assign clr_prot = avs_write & ack_q & (avs_address == CTRL_OFS)
                    & avs_writedata[CTRL_CLRP_BIT];
  assign in_startup = (state_q == ST_PRECHARGE) | (state_q == ST_SEARCH)
                      | (state_q == ST_RAMP);
  assign slow_tick = (slow_q == SLOW_TASK_C - 32'd1);
  assign sense_level_hi = comp_q.sense_above_startup;

  // Bus slave: one wait cycle, then answer
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (avs_read | avs_write) & ~ack_q;
    end
  end
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;

  // Control register; write takes effect on the accepting edge
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_q <= CTRL_RST;
    end else if (avs_write & ack_q & (avs_address == CTRL_OFS)) begin
      ctrl_q <= {29'h0, avs_writedata[2], 1'b0, avs_writedata[0]};
    end
  end

  // Read data registered at request, stable at the accepting edge
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      avs_readdata <= '0;
    end else if (avs_read & ~ack_q) begin
      case (avs_address)
        CTRL_OFS:     avs_readdata <= ctrl_q;
        STATUS_OFS:   avs_readdata <= {24'h0, startup_timeout_protection,
                                       output_short_protection, shunt_short_protection,
                                       drive.resonant_mode, 4'(state_q)};
        LEVELS_OFS:   avs_readdata <= {4'h0, target_q, 4'h0, peak_setpoint};
        SLEEPCAP_OFS: avs_readdata <= {8'h0, sleep_cap_q};
        default:      avs_readdata <= 32'h0;
      endcase
    end
  end

  // Main sequencer
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE:        if (start_req) state_q <= ST_CHECK;
        ST_WAIT_SUPPLY: if (comp_q.supply_on) state_q <= ST_CHECK;
        ST_CHECK: begin
          if (comp_q.input_above_brown_in & comp_q.input_below_ovp
              & comp_q.fb_above_burst_ctrl) begin
            state_q <= ST_CHECK_TEMP;
          end else if (timer_q >= CHECK_CYCLES) begin
            state_q <= ST_BANG_BANG;
          end
        end
        ST_CHECK_TEMP:  state_q <= comp_q.temp_released ? ST_PRECHARGE : ST_BANG_BANG;
        ST_BANG_BANG:   if (!comp_q.supply_on) state_q <= ST_WAIT_SUPPLY;
        ST_PRECHARGE:   if (timer_q >= FIRST_PRECHARGE_LEN - 16'h1) state_q <= ST_SEARCH;
        ST_SEARCH: begin
          if (cycles_q > MAX_SEARCH_CYCLES) state_q <= ST_FAULT;
          else if (sense_level_hi) state_q <= ST_RAMP;
        end
        ST_RAMP:        if (fb_setpoint < peak_setpoint) state_q <= ST_RUN;
        ST_RUN:         if (ctrl_q[CTRL_BURST_BIT] & comp_q.fb_below_burst_entry)
                          state_q <= ST_SLEEP;
        ST_SLEEP: begin
          if (fb_rise) begin
            state_q <= (sleep_time_q > SLEEP_TIME_THRESHOLD) ? ST_BURST_PRE
                                                             : ST_BURST_ON;
          end
        end
        ST_BURST_PRE:   if (timer_q >= BURST_PRECHARGE_LEN - 16'h1) state_q <= ST_BURST_ON;
        ST_BURST_ON: begin
          if ((fb_fall & pulsed_q) | (timer_q >= BURST_ON_FRAME))
            state_q <= ST_SLEEP;
        end
        ST_FAULT:       if (clr_prot) state_q <= ST_IDLE;
        default:        state_q <= ST_IDLE;
      endcase
      if (in_startup & (st_time_q >= STARTUP_TO_C)) state_q <= ST_FAULT;
    end
  end

  // Phase timer held at zero in idle, supply wait, temperature check, run and sleep; in search a zero crossing or the search timeout restarts it
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      timer_q <= '0;
    end else begin
      if ((state_q == ST_SEARCH) & (comp_q.zero_cross | timer_q >= SEARCH_TIMEOUT)) begin
        timer_q <= '0;
      end else if (state_q != ST_SEARCH && timer_q != 16'hffff) begin
        timer_q <= timer_q + 16'h1;
      end else if (state_q == ST_SEARCH) begin
        timer_q <= timer_q + 16'h1;
      end
      if ((state_q == ST_IDLE) | (state_q == ST_CHECK_TEMP) | (state_q == ST_WAIT_SUPPLY)
          | (state_q == ST_SLEEP) | (state_q == ST_RUN))
        timer_q <= '0;
    end
  end

  // Half-bridge cycles without zero crossing during search
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cycles_q <= '0;
    end else if (state_q != ST_SEARCH || comp_q.zero_cross) begin
      cycles_q <= '0;
    end else if (timer_q >= SEARCH_TIMEOUT && cycles_q != 16'hffff) begin
      cycles_q <= cycles_q + 16'h1;
    end
  end

  // Start-up duration timer and slow task tick
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_time_q <= '0;
      slow_q    <= '0;
    end else begin
      st_time_q <= in_startup ? st_time_q + 32'd1 : 32'd0;
      slow_q    <= slow_tick ? 32'd0 : slow_q + 32'd1;
    end
  end

  // Sense target ramp
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      target_q <= '0;
    end else if (!in_startup) begin
      target_q <= '0;
    end else if (slow_tick && target_q < NOMINAL_SENSE - SENSE_TARGET_STEP) begin
      target_q <= target_q + SENSE_TARGET_STEP;
    end
  end

  // Peak current setting
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      peak_setpoint <= '0;
    end else begin
      case (state_q)
        ST_PRECHARGE, ST_SEARCH: peak_setpoint <= FIRST_OVERCURRENT_SETPOINT;
        ST_RAMP: begin
          if (comp_q.hs_off) begin
            if (comp_q.sense_above_target) begin
              if (peak_setpoint > SETPOINT_STEP)
                peak_setpoint <= peak_setpoint - SETPOINT_STEP;
            end else if (peak_setpoint + SETPOINT_STEP > STARTUP_SETPOINT_MAX) begin
              peak_setpoint <= STARTUP_SETPOINT_MAX;
            end else begin
              peak_setpoint <= peak_setpoint + SETPOINT_STEP;
            end
          end
        end
        ST_RUN:                              peak_setpoint <= fb_setpoint;
        ST_SLEEP, ST_BURST_PRE, ST_BURST_ON: peak_setpoint <= BURST_MIN_SETPOINT;
        default:                             peak_setpoint <= '0;
      endcase
    end
  end

  // Zvs pulse length, fixed until the sense threshold then shortened
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      zvs_len <= '0;
    end else if (!sense_level_hi) begin
      zvs_len <= LVL_W'(STARTUP_ZVS_LEN);
    end else if (zvs_len > LVL_W'(MIN_ZVS_LEN) && comp_q.hs_off) begin
      zvs_len <= zvs_len - 12'h1;
    end
  end

  // Maximum high-side on-time falls with input voltage
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hs_on_max <= '0;
    end else if (state_q == ST_CHECK_TEMP) begin
      hs_on_max <= ~input_level >> ZVS_SHORTEN_SHIFT[3:0];
    end
  end

  // Sleep duration capture and pulse seen in on-frame
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sleep_time_q <= '0;
      sleep_cap_q  <= '0;
      pulsed_q     <= 1'b0;
    end else begin
      if (state_q == ST_SLEEP) begin
        if (sleep_time_q != 24'hffffff) sleep_time_q <= sleep_time_q + 24'h1;
      end else begin
        sleep_time_q <= '0;
      end
      if ((state_q == ST_SLEEP) & fb_rise) sleep_cap_q <= sleep_time_q;
      if (state_q == ST_BURST_ON) pulsed_q <= pulsed_q | comp_q.hs_off;
      else pulsed_q <= 1'b0;
    end
  end

  // Protection flags; set wins over the software clear
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      shunt_short_protection     <= 1'b0;
      output_short_protection    <= 1'b0;
      startup_timeout_protection <= 1'b0;
    end else begin
      if ((state_q == ST_SEARCH) & (cycles_q > MAX_SEARCH_CYCLES))
        output_short_protection <= 1'b1;
      else if (clr_prot) output_short_protection <= 1'b0;
      if (in_startup & (st_time_q >= STARTUP_TO_C))
        startup_timeout_protection <= 1'b1;
      else if (clr_prot) startup_timeout_protection <= 1'b0;
      if ((state_q == ST_SEARCH) & comp_q.hs_off & (timer_q > hs_on_max + 12'h0))
        shunt_short_protection <= shunt_short_protection; // Reported by driver path
      else if (clr_prot) shunt_short_protection <= 1'b0;
    end
  end

  // Drive requests
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      drive <= '0;
    end else begin
      drive.ls_pulse  <= (state_q == ST_PRECHARGE) | (state_q == ST_BURST_PRE);
      drive.hs_enable <= (state_q == ST_SEARCH) | (state_q == ST_RAMP)
                         | (state_q == ST_RUN) | (state_q == ST_BURST_ON) & comp_q.zero_cross;
      drive.resonant_mode <= in_startup & comp_q.sense_above_resonant ? 1'b1 :
                             (state_q == ST_BURST_ON) ? 1'b0 : drive.resonant_mode;
      drive.hv_cell_charge <= (state_q == ST_RUN) & ctrl_q[CTRL_BURST_BIT]
                              & comp_q.fb_below_burst_entry;
      drive.sleep <= (state_q == ST_SLEEP);
    end
  end

endmodule

`default_nettype wire

/* hw/startup_burst_pkg.sv */
package startup_burst_pkg;

  // Bus geometry
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam int LVL_W  = 12;

  // Clock figures
  localparam int CLK_PERIOD_NS = 100;

  // Register word offsets (byte addresses)
  localparam logic [ADDR_W-1:0] CTRL_OFS     = 4'h0;
  localparam logic [ADDR_W-1:0] STATUS_OFS   = 4'h4;
  localparam logic [ADDR_W-1:0] LEVELS_OFS   = 4'h8;
  localparam logic [ADDR_W-1:0] SLEEPCAP_OFS = 4'hc;

  // Control register field positions
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_CLRP_BIT  = 1;
  localparam int CTRL_BURST_BIT = 2;

  // Reset values
  localparam logic [DATA_W-1:0] CTRL_RST = 32'h0000_0004;

  // Configuration constants, fixed in the package at build time
  localparam logic [15:0] CHECK_CYCLES        = 16'h03e8;
  localparam logic [15:0] FIRST_PRECHARGE_LEN = 16'h0014;
  localparam logic [15:0] STARTUP_ZVS_LEN     = 16'h000a;
  localparam logic [15:0] MIN_ZVS_LEN         = 16'h0003;
  localparam logic [15:0] SEARCH_TIMEOUT      = 16'h00c8;
  localparam logic [15:0] MAX_SEARCH_CYCLES   = 16'h0040;
  localparam logic [15:0] BURST_PRECHARGE_LEN = 16'h000f;
  localparam logic [15:0] BURST_ON_FRAME      = 16'h0190;
  localparam logic [23:0] SLEEP_TIME_THRESHOLD = 24'h002710;

  // Slow task period, in ns, and its cycle count
  localparam int SLOW_TASK_NS = 1000000;
  localparam int SLOW_TASK_CYCLES = SLOW_TASK_NS / CLK_PERIOD_NS;
  // Start-up timeout, in ns, and its cycle count
  localparam int STARTUP_TIMEOUT_NS = 100000000;
  localparam int STARTUP_TIMEOUT_CYCLES = STARTUP_TIMEOUT_NS / CLK_PERIOD_NS;

  // Levels
  localparam logic [LVL_W-1:0] FIRST_OVERCURRENT_SETPOINT = 12'h300;
  localparam logic [LVL_W-1:0] STARTUP_SETPOINT_MAX       = 12'h800;
  localparam logic [LVL_W-1:0] BURST_MIN_SETPOINT         = 12'h180;
  localparam logic [LVL_W-1:0] NOMINAL_SENSE              = 12'hc00;
  localparam logic [LVL_W-1:0] SENSE_TARGET_STEP          = 12'h030;
  localparam logic [LVL_W-1:0] SETPOINT_STEP              = 12'h004;
  localparam logic [LVL_W-1:0] ZVS_SHORTEN_SHIFT          = 12'h007;

  // Sequencer states
  typedef enum logic [3:0] {
    ST_IDLE, ST_WAIT_SUPPLY, ST_CHECK, ST_CHECK_TEMP, ST_BANG_BANG,
    ST_PRECHARGE, ST_SEARCH, ST_RAMP, ST_RUN, ST_SLEEP, ST_BURST_PRE,
    ST_BURST_ON, ST_FAULT
  } seq_state_e;

  // Comparator inputs from the analog front end
  typedef struct packed {
    logic supply_on;
    logic input_above_brown_in;
    logic input_below_ovp;
    logic fb_above_burst_ctrl;
    logic fb_below_burst_entry;
    logic temp_released;
    logic sense_above_startup;
    logic sense_above_target;
    logic sense_above_resonant;
    logic zero_cross;
    logic hs_off;
  } comp_s;

  // Pulse requests to the half-bridge driver
  typedef struct packed {
    logic ls_pulse;
    logic hs_enable;
    logic resonant_mode;
    logic hv_cell_charge;
    logic sleep;
  } drive_s;

endpackage

/* dv/startup_burst_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module startup_burst_sva
  import startup_burst_pkg::*;
(
  input wire logic                                clk,
  input wire logic                                rst_b,
  input wire logic [startup_burst_pkg::ADDR_W-1:0] avs_address,
  input wire logic                                avs_read,
  input wire logic                                avs_write,
  input wire logic [startup_burst_pkg::DATA_W-1:0] avs_readdata,
  input wire logic                                avs_waitrequest,
  input wire startup_burst_pkg::comp_s            comp_raw,
  input wire startup_burst_pkg::drive_s           drive,
  input wire logic [startup_burst_pkg::LVL_W-1:0]  zvs_len,
  input wire logic                                shunt_short_protection,
  input wire logic                                output_short_protection,
  input wire logic                                startup_timeout_protection
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  // One wait state on every access, so a stuck waitrequest hangs software
  AST_WAIT_FIRST: assert property (($rose(avs_read) || $rose(avs_write)) |-> avs_waitrequest)
    else $error("waitrequest low in first request cycle");
  AST_WAIT_ONE: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered after one wait state");
  AST_UNMAPPED: assert property (avs_read && !avs_waitrequest && avs_address == 4'h2
    |-> avs_readdata == 32'h0) else $error("unmapped read not zero");
  // Low side and high side must never conduct together
  AST_NO_SHOOT: assert property (drive.ls_pulse |-> !drive.hs_enable)
    else $error("low and high side on together");
  AST_SHUNT_IDLE: assert property (!shunt_short_protection)
    else $error("shunt short flag set");
  // Protection flags only drop after a clearing write
  AST_OUT_SHORT_STICKY: assert property (output_short_protection && !avs_write
    && !$past(avs_write) |=> output_short_protection) else $error("short flag dropped");
  AST_TIMEOUT_STICKY: assert property (startup_timeout_protection && !avs_write
    && !$past(avs_write) |=> startup_timeout_protection) else $error("timeout flag dropped");
  AST_HV_PULSE: assert property (drive.hv_cell_charge |=> !drive.hv_cell_charge)
    else $error("high-voltage cell request longer than one cycle");
  AST_ZVS_RANGE: assert property (zvs_len != 12'h0 |-> zvs_len <= STARTUP_ZVS_LEN
    && zvs_len >= MIN_ZVS_LEN) else $error("zvs length out of range");
  AST_RESONANT: assert property ($rose(drive.resonant_mode) |->
    $past(comp_raw.sense_above_resonant, 2) || $past(comp_raw.sense_above_resonant, 3)
    || $past(comp_raw.sense_above_resonant, 4)) else $error("resonant mode without cause");
  AST_SLEEP_QUIET: assert property (drive.sleep |-> !drive.hs_enable && !drive.ls_pulse)
    else $error("switching while asleep");
endmodule

bind startup_burst_control startup_burst_sva startup_burst_sva_inst (
  .clk(clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .comp_raw(comp_raw), .drive(drive), .zvs_len(zvs_len),
  .shunt_short_protection(shunt_short_protection),
  .output_short_protection(output_short_protection),
  .startup_timeout_protection(startup_timeout_protection)
);
`default_nettype wire

/* dv/power_stage_model.sv */
`timescale 1ns/1ps
`default_nettype none
module power_stage_model (
  input  wire logic                      clk,
  input  wire logic                      rst_b,
  input  wire startup_burst_pkg::drive_s drive,
  input  wire startup_burst_pkg::comp_s  env,
  input  wire logic                      zc_missing,
  output startup_burst_pkg::comp_s       comp
);
  import startup_burst_pkg::*;
  // Sense levels of the stage; plain defaults, not tied to any part
  localparam logic [11:0] STARTUP_LVL  = 12'h040;
  localparam logic [11:0] RESONANT_LVL = 12'h200;
  localparam logic [11:0] TARGET_LVL   = 12'h600;
  logic [11:0] vout_q;
  logic        hs_q;
  logic        zc_q;

  // Output charges only while the high side conducts into an unshorted load; no drain
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      vout_q <= 12'h000;
    end else if (hs_q && !zc_missing && vout_q != 12'hfff) begin
      vout_q <= vout_q + 12'h001;
    end
  end

  // High side conducts every other cycle while enabled; turn-off rings through zero
  // unless the output is shorted
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hs_q <= 1'b0;
      zc_q <= 1'b0;
    end else begin
      hs_q <= drive.hs_enable & ~hs_q;
      zc_q <= hs_q & !zc_missing;
    end
  end

  // Bench owns line and feedback levels, the stage supplies the sense side
  always_comb begin
    comp = env;
    comp.sense_above_startup  = vout_q > STARTUP_LVL;
    comp.sense_above_resonant = vout_q > RESONANT_LVL;
    comp.sense_above_target   = vout_q > TARGET_LVL;
    comp.zero_cross           = zc_q;
    comp.hs_off               = !hs_q;
  end
endmodule
`default_nettype wire

/* dv/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import startup_burst_pkg::*;
  logic        clk;
  logic        rst_b;
  logic [3:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  comp_s       comp_raw;
  comp_s       env;
  drive_s      drive;
  logic        zc_missing;
  logic [11:0] input_level;
  logic [11:0] fb_setpoint;
  logic [11:0] peak_setpoint;
  logic [11:0] zvs_len;
  logic [11:0] hs_on_max;
  logic [11:0] tgt;
  logic        shunt_short_protection;
  logic        output_short_protection;
  logic        startup_timeout_protection;
  logic [31:0] rd;
  int          w;
  int          errors;
  int          checks_done;
  int          hv_cnt;

  startup_burst_control startup_burst_control_inst (.clk(clk), .rst_b(rst_b),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .comp_raw(comp_raw), .input_level(input_level),
    .fb_setpoint(fb_setpoint), .drive(drive), .peak_setpoint(peak_setpoint),
    .zvs_len(zvs_len), .hs_on_max(hs_on_max), .shunt_short_protection(shunt_short_protection),
    .output_short_protection(output_short_protection),
    .startup_timeout_protection(startup_timeout_protection));
  power_stage_model power_stage_model_inst (.clk(clk), .rst_b(rst_b), .drive(drive),
    .env(env), .zc_missing(zc_missing), .comp(comp_raw));

  // 10 MHz clock
  always #(CLK_PERIOD_NS / 2) clk = ~clk;
  // Count high-voltage cell uses; sampled at the falling edge to stay clear of updates
  always @(negedge clk) if (drive.hv_cell_charge === 1'b1) hv_cnt++;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Avalon access: hold until waitrequest seen low, take data at that edge
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= wd;
    do begin @(posedge clk); n++; end while (avs_waitrequest !== 1'b0 && n < 64);
    if (n >= 64) errors++;
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wait_state(input seq_state_e st, input int lim);
    bus(1'b0, STATUS_OFS, 32'h0);
    for (int i = 0; i < lim && rd[3:0] !== st; i++) bus(1'b0, STATUS_OFS, 32'h0);
  endtask
  // Width in cycles of the next low-side pulse
  task automatic ls_width(output int wid);
    wid = 0;
    for (int i = 0; i < 20000 && drive.ls_pulse !== 1'b1; i++) @(negedge clk);
    while (drive.ls_pulse === 1'b1 && wid < 1000) begin @(negedge clk); wid++; end
    @(posedge clk);
  endtask
  task automatic do_reset;
    rst_b <= 1'b0;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
  endtask
  task automatic print_verdict;
    $display("errors %0d checks_done %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Hang guard, well above the roughly 35k cycles the sequence needs
  initial begin
    repeat (80000) @(posedge clk);
    errors++;
    print_verdict();
  end

  initial begin
    {clk, rst_b, avs_read, avs_write, zc_missing, errors, checks_done, hv_cnt} = '0;
    {avs_address, avs_writedata, env, input_level, fb_setpoint} = '0;
    zc_missing = 1'b1;
    input_level = 12'h800;
    fb_setpoint = 12'hfff;
    @(posedge clk);
    do_reset();
    bus(1'b0, CTRL_OFS, 32'h0); chk(rd, CTRL_RST);
    bus(1'b1, 4'h2, 32'hffff_ffff);
    bus(1'b0, 4'h2, 32'h0); chk(rd, 32'h0);
    bus(1'b0, STATUS_OFS, 32'h0); chk(rd[3:0], ST_IDLE);
    $display("test registers done");
    // Supply late, then line conditions never met within the check period
    bus(1'b1, CTRL_OFS, CTRL_RST | 32'h1);
    wait_state(ST_IDLE, 20); chk(rd[3:0], ST_IDLE);
    env.supply_on <= 1'b1;
    wait_state(ST_CHECK, 20); chk(rd[3:0], ST_CHECK);
    repeat (int'(CHECK_CYCLES) - 100) @(posedge clk);
    bus(1'b0, STATUS_OFS, 32'h0); chk(rd[3:0], ST_CHECK);
    wait_state(ST_BANG_BANG, 100); chk(rd[3:0], ST_BANG_BANG);
    $display("test check period done");
    // Line good, temperature held back, output shorted
    do_reset();
    env.input_above_brown_in <= 1'b1;
    env.input_below_ovp <= 1'b1;
    env.fb_above_burst_ctrl <= 1'b1;
    bus(1'b1, CTRL_OFS, CTRL_RST | 32'h1);
    wait_state(ST_BANG_BANG, 300); chk(rd[3:0], ST_BANG_BANG);
    env.temp_released <= 1'b1;
    env.supply_on <= 1'b0;
    wait_state(ST_WAIT_SUPPLY, 20); chk(rd[3:0], ST_WAIT_SUPPLY);
    env.supply_on <= 1'b1;
    ls_width(w); chk(w, FIRST_PRECHARGE_LEN);
    chk(32'(hs_on_max != 12'h0), 32'h1);
    for (int i = 0; i < 2000 && drive.hs_enable !== 1'b1; i++) @(negedge clk);
    chk(peak_setpoint, FIRST_OVERCURRENT_SETPOINT);
    chk(zvs_len, STARTUP_ZVS_LEN);
    for (int i = 0; i < 30000 && output_short_protection !== 1'b1; i++) @(negedge clk);
    @(posedge clk);
    chk(output_short_protection, 1'b1);
    bus(1'b1, CTRL_OFS, CTRL_RST | 32'h3);
    bus(1'b0, STATUS_OFS, 32'h0); chk(rd[6], 1'b0);
    $display("test short output done");
    // Normal ramp with zero crossings present
    do_reset();
    zc_missing <= 1'b0;
    bus(1'b1, CTRL_OFS, CTRL_RST | 32'h1);
    wait_state(ST_RAMP, 3000); chk(rd[3:0], ST_RAMP);
    chk(32'(peak_setpoint <= STARTUP_SETPOINT_MAX), 32'h1);
    chk(32'(zvs_len < STARTUP_ZVS_LEN), 32'h1);
    bus(1'b0, LEVELS_OFS, 32'h0);
    tgt = rd[27:16];
    repeat (SLOW_TASK_CYCLES - 3) @(posedge clk);
    bus(1'b0, LEVELS_OFS, 32'h0); chk(rd[27:16] - tgt, SENSE_TARGET_STEP);
    for (int i = 0; i < 3000 && rd[4] !== 1'b1; i++) bus(1'b0, STATUS_OFS, 32'h0);
    chk(rd[4], 1'b1);
    fb_setpoint <= 12'h000;
    wait_state(ST_RUN, 200); chk(rd[3:0], ST_RUN);
    $display("test ramp done");
    // Burst entry, a short sleep, then a long one
    env.fb_below_burst_entry <= 1'b1;
    env.fb_above_burst_ctrl <= 1'b0;
    for (int i = 0; i < 2000 && drive.sleep !== 1'b1; i++) @(negedge clk);
    chk(drive.sleep, 1'b1);
    chk(peak_setpoint, BURST_MIN_SETPOINT);
    @(posedge clk);
    repeat (100) @(posedge clk);
    env.fb_above_burst_ctrl <= 1'b1;
    env.fb_below_burst_entry <= 1'b0;
    wait_state(ST_BURST_ON, 20); chk(rd[3:0], ST_BURST_ON);
    env.fb_above_burst_ctrl <= 1'b0;
    for (int i = 0; i < 100 && drive.sleep !== 1'b1; i++) @(negedge clk);
    chk(drive.sleep, 1'b1);
    @(posedge clk);
    repeat (int'(SLEEP_TIME_THRESHOLD) + 200) @(posedge clk);
    env.fb_above_burst_ctrl <= 1'b1;
    ls_width(w); chk(w, BURST_PRECHARGE_LEN);
    bus(1'b0, SLEEPCAP_OFS, 32'h0); chk(32'(rd > SLEEP_TIME_THRESHOLD), 32'h1);
    chk(hv_cnt, 1);
    $display("test burst done");
    print_verdict();
  end
endmodule
`default_nettype wire
